// *** hdl/touch_ctl_pkg.sv ***
// package: register map, field positions and carrier types of the touch control/status block
package touch_ctl_pkg;
    // ********************************************************************
    // register offsets and widths
    // ********************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_MAIN_CONTROL = 8'h00;
    localparam logic [7:0] OFS_GENERAL_STATUS = 8'h02;
    localparam logic [7:0] OFS_INPUT_TOUCH_STATUS = 8'h03;
    localparam logic [7:0] OFS_LAMP_DONE_STATUS = 8'h04;
    localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // ********************************************************************
    // main control fields
    // ********************************************************************
    localparam int MC_GAIN_HI = 7;
    localparam int MC_GAIN_LO = 6;
    localparam int MC_STANDBY = 5;
    localparam int MC_DEEP_SLEEP = 4;
    localparam int MC_IRQ_PEND = 0;
    // ********************************************************************
    // general status fields
    // ********************************************************************
    localparam int GS_LAMP = 4;
    localparam int GS_RESET = 3;
    localparam int GS_MULTI = 2;
    localparam int GS_PATTERN = 1;
    localparam int GS_TOUCH = 0;
    // ********************************************************************
    // sizes
    // ********************************************************************
    localparam int N_INPUTS = 6;
    localparam int N_LAMPS = 2;
    // gain code to multiplier
    typedef enum logic [1:0]
    {
        GAIN_X1 = 2'b00,
        GAIN_X2 = 2'b01,
        GAIN_X4 = 2'b10,
        GAIN_X8 = 2'b11
    } gain_e;
    // register bus request from the serial engine
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;
    // events from the sensing and lamp engines
    typedef struct packed
    {
        logic [N_INPUTS-1:0] touch;
        logic [N_INPUTS-1:0] irq_en;
        logic [N_INPUTS-1:0] standby_mask;
        logic [N_LAMPS-1:0] lamp_done;
        logic [N_LAMPS-1:0] lamp_linked;
        logic multi_block;
        logic pattern;
        logic pattern_irq_en;
        logic reset_pin_release;
    } sense_s;
endpackage

// *** hdl/touch_gain_decode.sv ***
// gain code decoder shared by the active and standby scan paths
`timescale 1ns/100ps
module touch_gain_decode
(
    // gain code
    input wire logic [1:0] code,
    // multiplier 1, 2, 4 or 8
    output logic [3:0] multi_touch_block
);
    import touch_ctl_pkg::*;
    // one decoder for both power states, so gain cannot differ between them
    always_comb
    begin
        unique case (gain_e'(code))
            GAIN_X1: multi_touch_block = 4'h1;
            GAIN_X2: multi_touch_block = 4'h2;
            GAIN_X4: multi_touch_block = 4'h4;
            GAIN_X8: multi_touch_block = 4'h8;
        endcase
    end
endmodule

// *** hdl/touch_main_control_status.sv ***
// main control and status registers of the six-input touch controller
//
// Behaviour
// - two-bit gain field selects gain 1/2/4/8
// - same gain in active and standby
// - standby scans masked inputs, status held
// - linked lamps stay active in standby
// - unsampled inputs release, then stay untouched
// - wake pin high clears deep sleep outside four-wire mode
// - deep sleep stops scan, lamps, clears flags
// - alert low while interrupt pending set
// - touch without interrupt enable sets status only
// - host writes zero clears pending, status
// - standby wake output drops with pending
// - wake pin undriven in four-wire mode
// - lamp summary set if any lamp done
// - reset flag sets pending, clears with it
// - multi-touch block flag never sets pending
// - pattern flag, pending if enabled, held
// - touch summary set if any touch
// - inputs six..one in bits five..zero
// - touch bit clears on pending clear only if released
// - all status cleared entering deep sleep
// - input one to lamp one, two to two
// - lamp done set for host lamps only
// - lamp done cleared when pending cleared
`timescale 1ns/100ps
module touch_main_control_status
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access from the serial engine
    input wire touch_ctl_pkg::reg_req_s req,
    output logic [7:0] rdata,
    output logic rvalid,
    // events from sensing and lamp engines
    input wire touch_ctl_pkg::sense_s sense,
    // serial configuration and wake pin
    input wire logic spi_4wire,
    input wire logic wake_in,
    output logic wake_out,
    output logic wake_oe,
    // alert pin, active low
    output logic alert_n,
    // controls to the sensing and lamp engines
    output logic [3:0] gain_multi_touch_block,
    output logic [5:0] scan_enable,
    output logic [1:0] lamp_link_active,
    output logic lamp_pwm_enable,
    output logic standby_active,
    output logic deep_sleep_active
);
    import touch_ctl_pkg::*;

    // ********************************************************************
    // state
    // ********************************************************************
    logic [1:0] gain_r; // gain code
    logic standby_r; // standby enable
    logic deep_sleep_r; // deep sleep enable
    logic irq_pend_r; // interrupt pending
    logic [5:0] touch_r; // per-input touch status
    logic [1:0] lamp_done_r; // lamp done status
    logic reset_flag_r; // came-out-of-reset flag
    logic pattern_r; // pattern touch flag
    logic wake_r; // wake output level
    logic wake_from_standby_r; // wake was raised by a standby touch
    logic por_pend_r; // one-shot after power-on release
    logic [3:0] gain_multi_touch_block_nxt; // decoded gain

    // ********************************************************************
    // decode helpers
    // ********************************************************************
    logic wr_main; // write to main control
    logic clr_pend; // host clears pending
    logic enter_sleep; // deep sleep rising now
    logic [5:0] sampled; // inputs currently scanned
    logic [5:0] touch_eff; // touches seen after scan mask
    logic [5:0] touch_new; // newly set touch bits
    logic touch_irq; // enabled new touch
    logic reset_evt; // reset exit event
    logic pattern_irq; // pattern raises pending
    logic [1:0] lamp_evt; // host-lamp done events
    logic [7:0] gen_status; // assembled general status

    assign wr_main = req.wr && (req.addr == OFS_MAIN_CONTROL);
    assign clr_pend = wr_main && !req.wdata[MC_IRQ_PEND] && irq_pend_r;
    // the pin only overrides the write while it is a wake pin, not spi data
    assign enter_sleep = wr_main && req.wdata[MC_DEEP_SLEEP] && !deep_sleep_r
        && !(wake_in && !spi_4wire);
    // standby limits scanning to the mask; deep sleep stops it all
    assign sampled = deep_sleep_r ? 6'h00 : (standby_r ? sense.standby_mask : 6'h3f);
    // unsampled inputs read as untouched, which reports their release
    assign touch_eff = sense.touch & sampled;
    assign touch_new = touch_eff & ~touch_r;
    assign touch_irq = |(touch_new & sense.irq_en);
    assign reset_evt = por_pend_r || sense.reset_pin_release;
    assign pattern_irq = sense.pattern && !pattern_r && sense.pattern_irq_en;
    // done events from linked lamps are ignored
    assign lamp_evt = sense.lamp_done & ~sense.lamp_linked;

    // ********************************************************************
    // general status layout
    // ********************************************************************
    always_comb
    begin
        gen_status = 8'h00;
        gen_status[GS_LAMP] = |lamp_done_r;
        gen_status[GS_RESET] = reset_flag_r;
        // live level: only blocks touches, so it is not sticky
        gen_status[GS_MULTI] = sense.multi_block && !deep_sleep_r;
        gen_status[GS_PATTERN] = pattern_r;
        gen_status[GS_TOUCH] = |touch_r;
    end

    // ********************************************************************
    // gain decode, one path for both power states
    // ********************************************************************
    touch_gain_decode u_gain
    (
        .code(gain_r),
        .multi_touch_block(gain_multi_touch_block_nxt)
    );

    // ********************************************************************
    // main control fields
    // ********************************************************************
    // gain and standby are plain host bits
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gain_r <= RST_MAIN_CONTROL[MC_GAIN_HI:MC_GAIN_LO];
            standby_r <= RST_MAIN_CONTROL[MC_STANDBY];
        end
        else if (wr_main)
        begin
            gain_r <= req.wdata[MC_GAIN_HI:MC_GAIN_LO];
            standby_r <= req.wdata[MC_STANDBY];
        end
    end

    // deep sleep: the wake pin wins over a host write in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            deep_sleep_r <= RST_MAIN_CONTROL[MC_DEEP_SLEEP];
        else if (wake_in && !spi_4wire)
            deep_sleep_r <= 1'b0;
        else if (wr_main)
            deep_sleep_r <= req.wdata[MC_DEEP_SLEEP];
    end

    // power-on one-shot, set by reset, dropped at the first edge after release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            por_pend_r <= 1'b1;
        else
            por_pend_r <= 1'b0;
    end

    // interrupt pending: new events win over the host clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_pend_r <= 1'b0;
        else if (enter_sleep)
            irq_pend_r <= 1'b0;
        else if (touch_irq || reset_evt || pattern_irq)
            irq_pend_r <= 1'b1;
        else if (clr_pend)
            irq_pend_r <= 1'b0;
    end

    // ********************************************************************
    // status registers
    // ********************************************************************
    // touch bits: set on touch, clear on pending clear only once released
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            touch_r <= RST_STATUS[5:0];
        else if (enter_sleep || deep_sleep_r)
            touch_r <= 6'h00;
        else if (clr_pend)
            touch_r <= touch_eff;
        else
            touch_r <= touch_r | touch_eff;
    end

    // lamp done bits: set wins over the pending clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            lamp_done_r <= RST_STATUS[1:0];
        else if (enter_sleep || deep_sleep_r)
            lamp_done_r <= 2'b00;
        else if (clr_pend)
            lamp_done_r <= lamp_evt;
        else
            lamp_done_r <= lamp_done_r | lamp_evt;
    end

    // reset flag: cleared with pending, a fresh reset event wins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reset_flag_r <= 1'b0;
        else if (reset_evt)
            reset_flag_r <= 1'b1;
        else if (enter_sleep || clr_pend)
            reset_flag_r <= 1'b0;
    end

    // pattern flag: held until a pending clear once the condition is gone
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pattern_r <= 1'b0;
        else if (enter_sleep || deep_sleep_r)
            pattern_r <= 1'b0;
        else if (sense.pattern)
            pattern_r <= 1'b1;
        else if (clr_pend)
            pattern_r <= 1'b0;
    end

    // ********************************************************************
    // wake output
    // ********************************************************************
    // raised by an enabled touch in standby, dropped with pending
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wake_r <= 1'b0;
            wake_from_standby_r <= 1'b0;
        end
        else if (enter_sleep)
        begin
            // sleep entry drops pending, so the wake flag must not outlive it
            wake_r <= 1'b0;
            wake_from_standby_r <= 1'b0;
        end
        else if (standby_r && touch_irq)
        begin
            wake_r <= 1'b1;
            wake_from_standby_r <= 1'b1;
        end
        else if (clr_pend && wake_from_standby_r)
        begin
            wake_r <= 1'b0;
            wake_from_standby_r <= 1'b0;
        end
    end

    // the pin is shared with the spi data input in four-wire mode
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wake_out <= 1'b0;
            wake_oe <= 1'b0;
        end
        else
        begin
            wake_out <= wake_r;
            wake_oe <= !spi_4wire;
        end
    end

    // ********************************************************************
    // outputs to pins and engines
    // ********************************************************************
    // registered copies; one cycle behind the state flops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            alert_n <= 1'b1;
            gain_multi_touch_block <= 4'h1;
            scan_enable <= 6'h00;
            lamp_link_active <= 2'b00;
            lamp_pwm_enable <= 1'b0;
            standby_active <= 1'b0;
            deep_sleep_active <= 1'b0;
        end
        else
        begin
            alert_n <= !irq_pend_r;
            gain_multi_touch_block <= gain_multi_touch_block_nxt;
            scan_enable <= sampled;
            // input one drives lamp one, input two lamp two, kept in standby
            lamp_link_active <= deep_sleep_r ? 2'b00 : sense.lamp_linked;
            lamp_pwm_enable <= !deep_sleep_r;
            standby_active <= standby_r;
            deep_sleep_active <= deep_sleep_r;
        end
    end

    // ********************************************************************
    // read path
    // ********************************************************************
    // unmapped offsets read as zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req.rd;
            if (req.rd)
            begin
                unique case (req.addr)
                    OFS_MAIN_CONTROL:
                        rdata <= {gain_r, standby_r, deep_sleep_r, 3'b000, irq_pend_r};
                    OFS_GENERAL_STATUS:
                        rdata <= gen_status;
                    OFS_INPUT_TOUCH_STATUS:
                        rdata <= {2'b00, touch_r};
                    OFS_LAMP_DONE_STATUS:
                        rdata <= {6'h00, lamp_done_r};
                    default:
                        rdata <= READ_UNMAPPED;
                endcase
            end
        end
    end
endmodule

// *** verification/touch_ctl_sva.sv ***
// checker: port timing relations of the touch control and status block
`timescale 1ns/100ps
module touch_ctl_sva
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host and sensing inputs
    input wire touch_ctl_pkg::reg_req_s req,
    input wire touch_ctl_pkg::sense_s sense,
    input wire logic spi_4wire,
    input wire logic wake_in,
    // observed outputs
    input wire logic wake_out,
    input wire logic wake_oe,
    input wire logic alert_n,
    input wire logic [3:0] gain_multi_touch_block,
    input wire logic [5:0] scan_enable,
    input wire logic lamp_pwm_enable,
    input wire logic standby_active,
    input wire logic deep_sleep_active
);
    import touch_ctl_pkg::*;
    // a pending clear with no new cause beside it, since set wins over clear
    logic clr_w;
    assign clr_w = req.wr && req.addr == OFS_MAIN_CONTROL && !req.wdata[MC_IRQ_PEND]
        && (sense.touch & sense.irq_en) == 6'h00 && !sense.reset_pin_release
        && !(sense.pattern && sense.pattern_irq_en) && sense.lamp_done == 2'b00;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_GAIN: assert property (req.wr && req.addr == OFS_MAIN_CONTROL
        |-> ##2 gain_multi_touch_block == (4'h1 << $past(req.wdata[7:6], 2)))
        else $error("gain multiplier differs from written code");
    AST_ALERT_CLR: assert property (clr_w |-> ##2 alert_n)
        else $error("alert still low after pending clear");
    AST_ALERT_SET: assert property (
        sense.reset_pin_release && !req.wr && !deep_sleep_active |-> ##2 !alert_n)
        else $error("reset pin release did not raise alert");
    AST_WAKE_OE: assert property (spi_4wire |=> !wake_oe)
        else $error("wake pin driven in four-wire mode");
    AST_WAKE_CLR: assert property (clr_w |-> ##[1:2] !wake_out)
        else $error("wake output kept after pending clear");
    AST_DS_WAKE: assert property (wake_in && !spi_4wire |-> ##2 !deep_sleep_active)
        else $error("wake pin did not end deep sleep");
    AST_DS_SCAN: assert property (deep_sleep_active && $past(deep_sleep_active)
        |-> scan_enable == 6'h00 && !lamp_pwm_enable)
        else $error("scan or pwm active in deep sleep");
    AST_STANDBY_ENABLE_SCAN: assert property (standby_active && $past(standby_active)
        && !deep_sleep_active && !$past(deep_sleep_active) && $stable(sense.standby_mask)
        |-> scan_enable == sense.standby_mask)
        else $error("standby scan differs from mask");
endmodule
bind touch_main_control_status touch_ctl_sva u_sva
(
    .clk(clk), .rst(rst), .req(req), .sense(sense), .spi_4wire(spi_4wire),
    .wake_in(wake_in), .wake_out(wake_out), .wake_oe(wake_oe), .alert_n(alert_n),
    .gain_multi_touch_block(gain_multi_touch_block), .scan_enable(scan_enable), .lamp_pwm_enable(lamp_pwm_enable),
    .standby_active(standby_active), .deep_sleep_active(deep_sleep_active)
);

// *** verification/touch_host_model.sv ***
// host model: register master issuing single-byte reads and writes
`timescale 1ns/100ps
module touch_host_model
(
    // clock
    input wire logic clk,
    // request towards the block
    output touch_ctl_pkg::reg_req_s req,
    // read answer
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import touch_ctl_pkg::*;
    initial req = '0;
    // one write strobe; a zero in the pending bit clears it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        // released lines show junk, not the old value
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one read strobe; data taken while rvalid stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
        @(negedge clk);
        d = rvalid ? rdata : 8'hxx;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
    endtask
endmodule

// *** verification/test_touch_main_control_status.sv ***
// testbench: register-level tests of the touch control and status block
`timescale 1ns/100ps
`define CHK(a, b) \
    begin \
        n_tests++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); \
        end \
    end
module test_touch_main_control_status;
    import touch_ctl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_s req;
    sense_s sense = '0;
    logic spi_4wire = 1'b0;
    logic wake_in = 1'b0;
    logic [7:0] rdata;
    logic rvalid, wake_out, wake_oe, alert_n, lamp_pwm_enable, standby_active;
    logic deep_sleep_active;
    logic [3:0] gain_multi_touch_block;
    logic [5:0] scan_enable;
    logic [1:0] lamp_link_active;
    int errors = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    touch_main_control_status dut
    (
        .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .sense(sense),
        .spi_4wire(spi_4wire), .wake_in(wake_in), .wake_out(wake_out), .wake_oe(wake_oe),
        .alert_n(alert_n), .gain_multi_touch_block(gain_multi_touch_block), .scan_enable(scan_enable),
        .lamp_link_active(lamp_link_active), .lamp_pwm_enable(lamp_pwm_enable),
        .standby_active(standby_active), .deep_sleep_active(deep_sleep_active)
    );
    touch_host_model host
    (
        .clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid)
    );
    // read one register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        `CHK(d, exp)
    endtask
    // let registered flags and the alert land
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask
    // raise pending by a reset pin release, so that a later zero write is a real clear
    task automatic pend_pulse();
        sense.reset_pin_release = 1'b1;
        @(negedge clk);
        sense.reset_pin_release = 1'b0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog: the tests need well under 1000 cycles
    initial
    begin
        #(4000 * 40);
        errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        settle();
        rchk(OFS_GENERAL_STATUS, 8'h08);
        `CHK(alert_n, 1'b0)
        rchk(OFS_MAIN_CONTROL, 8'h01);
        rchk(OFS_INPUT_TOUCH_STATUS, 8'h00);
        rchk(OFS_LAMP_DONE_STATUS, 8'h00);
        host.wr(OFS_GENERAL_STATUS, 8'hff);
        rchk(8'h01, 8'h00);
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        settle();
        `CHK(alert_n, 1'b1)
        rchk(OFS_GENERAL_STATUS, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            host.wr(OFS_MAIN_CONTROL, {i[1:0], i[2], 5'h00});
            rchk(OFS_MAIN_CONTROL, {i[1:0], i[2], 5'h00});
            `CHK(gain_multi_touch_block, 4'h1 << i[1:0])
        end
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        sense.touch = 6'h04;
        settle();
        rchk(OFS_MAIN_CONTROL, 8'h00);
        sense.touch = 6'h00;
        sense.irq_en = 6'h3f;
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        sense.touch = 6'h21;
        settle();
        // input three stays set from the unenabled touch: no pending clear since
        rchk(OFS_INPUT_TOUCH_STATUS, 8'h25);
        rchk(OFS_GENERAL_STATUS, 8'h01);
        `CHK(alert_n, 1'b0)
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        settle();
        `CHK(alert_n, 1'b1)
        sense.touch = 6'h00;
        rchk(OFS_INPUT_TOUCH_STATUS, 8'h21);
        pend_pulse();
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        rchk(OFS_INPUT_TOUCH_STATUS, 8'h00);
        sense.multi_block = 1'b1;
        settle();
        rchk(OFS_GENERAL_STATUS, 8'h04);
        `CHK(alert_n, 1'b1)
        sense.multi_block = 1'b0;
        sense.pattern = 1'b1;
        settle();
        rchk(OFS_MAIN_CONTROL, 8'h00);
        sense.pattern = 1'b0;
        pend_pulse();
        rchk(OFS_GENERAL_STATUS, 8'h0a);
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        sense.pattern_irq_en = 1'b1;
        sense.pattern = 1'b1;
        settle();
        `CHK(alert_n, 1'b0)
        sense.pattern = 1'b0;
        rchk(OFS_GENERAL_STATUS, 8'h02);
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        rchk(OFS_GENERAL_STATUS, 8'h00);
        sense.lamp_done = 2'b10;
        @(negedge clk);
        sense.lamp_done = 2'b00;
        rchk(OFS_LAMP_DONE_STATUS, 8'h02);
        rchk(OFS_GENERAL_STATUS, 8'h10);
        pend_pulse();
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        rchk(OFS_LAMP_DONE_STATUS, 8'h00);
        sense.lamp_linked = 2'b01;
        sense.lamp_done = 2'b01;
        @(negedge clk);
        sense.lamp_done = 2'b00;
        rchk(OFS_LAMP_DONE_STATUS, 8'h00);
        // standby: input one drops out of the scan
        sense.standby_mask = 6'h02;
        sense.touch = 6'h01;
        settle();
        host.wr(OFS_MAIN_CONTROL, 8'h20);
        pend_pulse();
        host.wr(OFS_MAIN_CONTROL, 8'h20);
        rchk(OFS_INPUT_TOUCH_STATUS, 8'h00);
        `CHK(scan_enable, 6'h02)
        `CHK(lamp_link_active, 2'b01)
        sense.touch = 6'h02;
        settle();
        `CHK({wake_oe, wake_out}, 2'b11)
        spi_4wire = 1'b1;
        settle();
        `CHK(wake_oe, 1'b0)
        spi_4wire = 1'b0;
        sense.touch = 6'h00;
        host.wr(OFS_MAIN_CONTROL, 8'h20);
        settle();
        `CHK(wake_out, 1'b0)
        host.wr(OFS_MAIN_CONTROL, 8'h00);
        // deep sleep entry with a pending touch
        sense.touch = 6'h01;
        settle();
        host.wr(OFS_MAIN_CONTROL, 8'h10);
        settle();
        rchk(OFS_INPUT_TOUCH_STATUS, 8'h00);
        rchk(OFS_MAIN_CONTROL, 8'h10);
        `CHK({scan_enable, lamp_pwm_enable, alert_n}, 8'h01)
        sense.touch = 6'h00;
        wake_in = 1'b1;
        settle();
        wake_in = 1'b0;
        rchk(OFS_MAIN_CONTROL, 8'h00);
        sense.reset_pin_release = 1'b1;
        @(negedge clk);
        sense.reset_pin_release = 1'b0;
        settle();
        rchk(OFS_GENERAL_STATUS, 8'h08);
        `CHK(alert_n, 1'b0)
        report_and_stop();
    end
endmodule
